//--- omcs_top.sv
// control/status logic of a pluggable optical module with its two-wire slave
`timescale 1ns/1ns
module omcs_top import omcs_pkg::*; #(
    parameter int T_SERIAL = T_SERIAL_CYC,
    parameter int T_DATA = T_DATA_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic txdis_pin,
    input wire logic laser_fault,
    input wire logic los_detect,
    output logic laser_en,
    output logic tx_fault,
    output logic rx_los
);
    if (T_SERIAL < 1 || T_DATA <= T_SERIAL || T_DATA >= 2 ** POR_W) begin : g_chk
        $error("power-on timer parameters out of range");
    end

    // pin synchronisers: stage 0 is read only by stage 1
    logic [2:0] pin_s0, pin_s1;
    logic [1:0] scl_s, sda_s, tog_s;
    logic scl_d, sda_d, tog_d;
    logic pin_dis, fault_s, los_s;

    // core state
    logic [POR_W-1:0] por_cnt, next_por_cnt;
    logic serial_ready, next_serial_ready;
    logic ready_n, next_ready_n;
    logic [DIS_W-1:0] dis_cnt, next_dis_cnt;
    logic fault_latched, next_fault_latched;
    logic soft_dis, next_soft_dis;
    logic pend_val, next_pend_val;
    logic pend_valid, next_pend_valid;
    omcs_phase_t phase, next_phase;
    logic space, next_space;
    logic [7:0] ptr, next_ptr;
    logic in_frame, next_in_frame;
    logic link_hold, next_link_hold;
    omcs_reply_t reply, next_reply;
    logic next_laser_en, next_tx_fault, next_rx_los;
    omcs_status_t status;
    logic start_det, stop_det, byte_ev, reset_fault;

    // link-side state
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shin, next_shin, byte_hold, next_byte_hold, shout, next_shout;
    logic byte_tog, next_byte_tog, mack, next_mack;
    logic sending, next_sending, next_sda_oe;

    assign pin_dis = pin_s1[2];
    assign fault_s = pin_s1[1];
    assign los_s = pin_s1[0];
    assign start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign stop_det = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    assign byte_ev = tog_s[1] ^ tog_d;

    always_comb begin
        status = '{txdis_state: pin_dis, soft_dis: soft_dis, rsv: RSV_VALUE,
                   tx_fault: fault_latched, rx_los: los_s, data_ready_n: ready_n};
    end

    function automatic logic [7:0] rd_value(input logic sp, input logic [7:0] off, input omcs_status_t st);
        rd_value = (sp && off == CTRL_STATUS_OFFSET) ? st : UNMAPPED_READ;
    endfunction : rd_value

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s0 <= 3'h0;
            pin_s1 <= 3'h0;
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            tog_s <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            tog_d <= 1'b0;
        end else begin
            pin_s0 <= {txdis_pin, laser_fault, los_detect};
            pin_s1 <= pin_s0;
            scl_s <= {scl_s[0], scl_clk};
            sda_s <= {sda_s[0], sda_i};
            tog_s <= {tog_s[0], byte_tog};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
            tog_d <= tog_s[1];
        end
    end

    // power-on timers and laser control
    always_comb begin
        next_por_cnt = (por_cnt == POR_W'(T_DATA)) ? por_cnt : por_cnt + 1'b1;
        // compare one count early so the flag lands on the limit, not a cycle past it
        next_serial_ready = serial_ready | (por_cnt == POR_W'(T_SERIAL - 1));
        next_ready_n = ready_n & (por_cnt != POR_W'(T_DATA - 1));
        next_dis_cnt = !pin_dis ? '0 : (dis_cnt == DIS_W'(T_RESET_CYC)) ? dis_cnt : dis_cnt + 1'b1;
        reset_fault = pin_dis && dis_cnt == DIS_W'(T_RESET_CYC - 1);
        // a fault still present wins over the clear
        next_fault_latched = fault_s | (fault_latched & ~reset_fault);
        next_laser_en = ~pin_dis & ~soft_dis & ~fault_latched;
        next_tx_fault = fault_latched;
        next_rx_los = los_s;
    end

    // two-wire transaction handling, one step per completed byte
    always_comb begin
        next_soft_dis = soft_dis;
        next_pend_val = pend_val;
        next_pend_valid = pend_valid;
        next_phase = phase;
        next_space = space;
        next_ptr = ptr;
        next_reply = reply;
        next_in_frame = in_frame;
        if (stop_det) begin
            if (pend_valid) begin
                next_soft_dis = pend_val;
            end
            next_pend_valid = 1'b0;
            next_phase = PH_IDLE;
            next_reply = '0;
            next_in_frame = 1'b0;
        end else if (start_det) begin
            next_phase = PH_DEV;
            next_reply = '0;
            next_in_frame = 1'b1;
        end else if (byte_ev) begin
            unique case (phase)
                PH_IDLE: begin
                    next_reply = '0;
                end
                PH_DEV: begin
                    // no answer at all before the serial port is ready
                    if (serial_ready && (byte_hold[7:1] == ID_SPACE_ADDR ||
                                         byte_hold[7:1] == DIAG_SPACE_ADDR)) begin
                        next_space = byte_hold[1];
                        next_reply.ack = 1'b1;
                        next_reply.send = byte_hold[0];
                        next_reply.rd_byte = rd_value(byte_hold[1], ptr, status);
                        next_ptr = byte_hold[0] ? ptr + 1'b1 : ptr;
                        next_phase = byte_hold[0] ? PH_READ : PH_PTR;
                    end else begin
                        next_reply = '0;
                        next_phase = PH_IDLE;
                    end
                end
                PH_PTR: begin
                    next_ptr = byte_hold;
                    next_reply = '{ack: 1'b1, send: 1'b0, rd_byte: 8'h00};
                    next_phase = PH_WDATA;
                end
                PH_WDATA: begin
                    // only the soft disable bit is writable; held until stop
                    if (space && ptr == CTRL_STATUS_OFFSET) begin
                        next_pend_val = byte_hold[6];
                        next_pend_valid = 1'b1;
                    end
                    next_ptr = ptr + 1'b1;
                    next_reply = '{ack: 1'b1, send: 1'b0, rd_byte: 8'h00};
                end
                PH_READ: begin
                    next_reply = '{ack: 1'b0, send: 1'b1, rd_byte: rd_value(space, ptr, status)};
                    next_ptr = ptr + 1'b1;
                end
            endcase
        end
        // link logic is held in reset between frames and for one cycle at any start
        next_link_hold = start_det | ~next_in_frame;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            por_cnt <= '0;
            serial_ready <= 1'b0;
            ready_n <= READY_N_RESET;
            dis_cnt <= '0;
            fault_latched <= 1'b0;
            soft_dis <= SOFT_DIS_RESET;
            pend_val <= 1'b0;
            pend_valid <= 1'b0;
            phase <= PH_IDLE;
            space <= 1'b0;
            ptr <= 8'h00;
            in_frame <= 1'b0;
            link_hold <= 1'b1;
            reply <= '0;
            laser_en <= 1'b0;
            tx_fault <= 1'b0;
            rx_los <= 1'b0;
        end else begin
            por_cnt <= next_por_cnt;
            serial_ready <= next_serial_ready;
            ready_n <= next_ready_n;
            dis_cnt <= next_dis_cnt;
            fault_latched <= next_fault_latched;
            soft_dis <= next_soft_dis;
            pend_val <= next_pend_val;
            pend_valid <= next_pend_valid;
            phase <= next_phase;
            space <= next_space;
            ptr <= next_ptr;
            in_frame <= next_in_frame;
            link_hold <= next_link_hold;
            reply <= next_reply;
            laser_en <= next_laser_en;
            tx_fault <= next_tx_fault;
            rx_los <= next_rx_los;
        end
    end

    // link side on the serial clock: receive on rising edges
    always_comb begin
        next_shin = {shin[6:0], sda_i};
        next_byte_hold = byte_hold;
        next_byte_tog = byte_tog;
        next_mack = mack;
        if (bit_cnt == 4'd8) begin
            next_bit_cnt = 4'd0;
            next_mack = sda_i;
        end else begin
            next_bit_cnt = bit_cnt + 4'd1;
            if (bit_cnt == 4'd7) begin
                // byte_hold stays put for nine clocks, so the core reads it safely
                next_byte_hold = {shin[6:0], sda_i};
                next_byte_tog = ~byte_tog;
            end
        end
    end

    always_ff @(posedge scl_clk or posedge link_hold) begin
        if (link_hold) begin
            bit_cnt <= 4'd0;
            shin <= 8'h00;
            byte_hold <= 8'h00;
            byte_tog <= 1'b0;
            mack <= 1'b1;
        end else begin
            bit_cnt <= next_bit_cnt;
            shin <= next_shin;
            byte_hold <= next_byte_hold;
            byte_tog <= next_byte_tog;
            mack <= next_mack;
        end
    end

    // drive on falling edges; reply was settled by the core a half clock earlier
    always_comb begin
        next_shout = shout;
        next_sending = sending;
        if (bit_cnt == 4'd8) begin
            next_sending = 1'b0;
            next_sda_oe = reply.ack;
        end else if (bit_cnt == 4'd0) begin
            // a master not-acknowledge ends the read burst
            next_sending = reply.send & ~mack;
            next_shout = reply.rd_byte;
            next_sda_oe = reply.send & ~mack & ~reply.rd_byte[7];
        end else begin
            next_sda_oe = sending & ~shout[3'd7 - bit_cnt[2:0]];
        end
    end

    always_ff @(negedge scl_clk or posedge link_hold) begin
        if (link_hold) begin
            shout <= 8'h00;
            sending <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            shout <= next_shout;
            sending <= next_sending;
            sda_oe <= next_sda_oe;
            sda_o <= 1'b0;
        end
    end

    pin_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(pin_dis) |-> ##1 !laser_en ##1 !laser_en) else $error("laser on after disable pin rose");
    pin_on_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(pin_dis) && !soft_dis && !fault_latched ##1 !soft_dis && !fault_latched |-> ##1 laser_en)
        else $error("laser stays off after disable pin fell");
    soft_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(soft_dis) |-> ##1 !laser_en) else $error("laser on after soft disable");
    soft_on_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(soft_dis) && !pin_dis && !fault_latched ##1 !pin_dis && !fault_latched |-> ##1 laser_en)
        else $error("laser off after soft enable");
    fault_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
        fault_s |-> ##1 status.tx_fault) else $error("fault status bit not set");
    los_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(los_s) |-> ##1 rx_los == $past(los_s) && status.rx_los == rx_los)
        else $error("loss bit not following detector");
    ready_time_a: assert property (@(posedge core_clk) disable iff (!nrst)
        por_cnt == POR_W'(T_DATA) |-> !ready_n) else $error("data ready late");
    early_ack_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !serial_ready |-> !reply.ack && !reply.send) else $error("bus answered before ready");
    write_commit_a: assert property (@(posedge core_clk) disable iff (!nrst)
        stop_det && pend_valid |=> soft_dis == $past(pend_val) && !pend_valid) else $error("write not committed");
    fault_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(fault_latched) |-> $past(pin_dis) && $past(dis_cnt) == DIS_W'(T_RESET_CYC - 1))
        else $error("fault cleared without reset hold");
endmodule : omcs_top

//--- omcs_pkg.sv
// shared constants and types of the optical module control/status block
package omcs_pkg;
    localparam int CLK_KHZ = 50000;
    localparam int T_RESET_US = 10;
    localparam int T_SERIAL_MS = 300;
    localparam int T_DATA_MS = 1000;
    localparam int T_RESET_CYC = (T_RESET_US * CLK_KHZ + 999) / 1000;
    localparam int T_SERIAL_CYC = T_SERIAL_MS * CLK_KHZ;
    localparam int T_DATA_CYC = T_DATA_MS * CLK_KHZ;
    localparam int POR_W = 26;
    localparam int DIS_W = 9;
    localparam logic [6:0] ID_SPACE_ADDR = 7'h50;
    localparam logic [6:0] DIAG_SPACE_ADDR = 7'h51;
    localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h6e;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic SOFT_DIS_RESET = 1'b0;
    localparam logic READY_N_RESET = 1'b1;
    localparam logic [2:0] RSV_VALUE = 3'h0;

    typedef struct packed {
        logic txdis_state;
        logic soft_dis;
        logic [2:0] rsv;
        logic tx_fault;
        logic rx_los;
        logic data_ready_n;
    } omcs_status_t;

    typedef struct packed {
        logic ack;
        logic send;
        logic [7:0] rd_byte;
    } omcs_reply_t;

    typedef enum logic [2:0] {PH_IDLE, PH_DEV, PH_PTR, PH_WDATA, PH_READ} omcs_phase_t;
endpackage : omcs_pkg

//--- omcs_host.sv
// host model: drives the two-wire bus of the module from its own link clock
`timescale 1ns/1ns
module omcs_host (
    output logic scl_clk,
    output logic sda_i,
    input wire logic sda_oe
);
    logic lclk = 1'b0;
    logic pull = 1'b0;

    // 30 ns tick, offset so it never lines up with the core clock
    initial begin
        #7;
        forever #15 lclk = ~lclk;
    end
    initial scl_clk = 1'b1;
    // pull-up: a released line reads high, never the last driven value
    assign sda_i = ~(pull | sda_oe);

    task automatic tk(input int n);
        repeat (n) @(posedge lclk);
    endtask : tk

    // low 45 ticks, high 25 ticks: inside the slave's timing needs
    task automatic bit_io(input logic b, output logic r);
        pull <= ~b;
        tk(25);
        scl_clk <= 1'b1;
        tk(12);
        r = sda_i;
        tk(13);
        scl_clk <= 1'b0;
        tk(20);
    endtask : bit_io

    task automatic start();
        pull <= 1'b0;
        tk(25);
        scl_clk <= 1'b1;
        tk(25);
        pull <= 1'b1;
        tk(25);
        scl_clk <= 1'b0;
        tk(20);
    endtask : start

    task automatic stop();
        pull <= 1'b1;
        tk(25);
        scl_clk <= 1'b1;
        tk(25);
        pull <= 1'b0;
        tk(25);
    endtask : stop

    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put

    // last high means nack, which ends the read
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : get
endmodule : omcs_host

//--- test_omcs_top.sv
// self-checking bench of the optical module control/status block
`timescale 1ns/1ns
module test_omcs_top;
    localparam int T_SER = 2000;
    localparam int T_DAT = 60000;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic txdis_pin = 1'b0;
    logic laser_fault = 1'b0;
    logic los_detect = 1'b0;
    logic scl_clk, sda_i, sda_o, sda_oe, laser_en, tx_fault, rx_los;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic ok;
    logic [7:0] q;

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= nrst ? cyc + 1 : 0;

    omcs_top #(.T_SERIAL(T_SER), .T_DATA(T_DAT)) uut (
        .core_clk(core_clk), .nrst(nrst), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
        .txdis_pin(txdis_pin), .laser_fault(laser_fault), .los_detect(los_detect),
        .laser_en(laser_en), .tx_fault(tx_fault), .rx_los(rx_los)
    );
    omcs_host host (.scl_clk(scl_clk), .sda_i(sda_i), .sda_oe(sda_oe));

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic wr(input logic [6:0] dev, input logic [7:0] dat, output logic all);
        logic a1, a2, a3;
        host.start();
        host.put({dev, 1'b0}, a1);
        host.put(8'h6e, a2);
        host.put(dat, a3);
        host.stop();
        all = a1 & a2 & a3;
    endtask : wr

    task automatic rd(input logic [6:0] dev, output logic [7:0] d, output logic all);
        logic a1, a2, a3;
        host.start();
        host.put({dev, 1'b0}, a1);
        host.put(8'h6e, a2);
        host.start();
        host.put({dev, 1'b1}, a3);
        host.get(1'b1, d);
        host.stop();
        all = a1 & a2 & a3;
    endtask : rd

    task automatic set(input logic td, input logic lf, input logic ld);
        @(posedge core_clk);
        txdis_pin <= td;
        laser_fault <= lf;
        los_detect <= ld;
    endtask : set

    // pins settle within a fixed few core edges of a synced input change
    task automatic pins(input logic [2:0] e);
        repeat (8) @(posedge core_clk);
        chk({4'h0, sda_o, laser_en, tx_fault, rx_los}, {5'h0, e});
    endtask : pins

    initial begin
        repeat (3) @(posedge core_clk);
        chk({5'h0, laser_en, tx_fault, rx_los}, 8'h00);
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        // too early: refused, and nothing commits
        wr(7'h51, 8'h40, ok);
        chk({7'h0, ok}, 8'h00);
        pins(3'b100);
        rd(7'h51, q, ok);
        chk({7'h0, ok}, 8'h01);
        chk(q, 8'h01);
        rd(7'h50, q, ok);
        chk({6'h0, ok, q[0]}, 8'h02);
        wr(7'h30, 8'h40, ok);
        chk({7'h0, ok}, 8'h00);
        wr(7'h51, 8'h40, ok);
        chk({7'h0, ok}, 8'h01);
        pins(3'b000);
        rd(7'h51, q, ok);
        chk(q, 8'h41);
        // burst from the byte below: pointer steps once per data byte, master ack keeps it going
        host.start();
        host.put(8'ha2, ok);
        host.put(8'h6d, ok);
        host.start();
        host.put(8'ha3, ok);
        host.get(1'b0, q);
        chk(q, 8'h00);
        host.get(1'b1, q);
        host.stop();
        chk(q, 8'h41);
        wr(7'h51, 8'h00, ok);
        pins(3'b100);
        set(1'b1, 1'b0, 1'b0);
        pins(3'b000);
        set(1'b0, 1'b0, 1'b0);
        pins(3'b100);
        set(1'b0, 1'b1, 1'b1);
        pins(3'b011);
        set(1'b0, 1'b0, 1'b1);
        rd(7'h51, q, ok);
        chk(q, 8'h07);
        set(1'b0, 1'b0, 1'b0);
        pins(3'b010);
        rd(7'h51, q, ok);
        chk(q, 8'h05);
        // a disable pulse shorter than the reset time leaves the fault latched
        set(1'b1, 1'b0, 1'b0);
        repeat (100) @(posedge core_clk);
        set(1'b0, 1'b0, 1'b0);
        pins(3'b010);
        set(1'b1, 1'b0, 1'b0);
        rd(7'h51, q, ok);
        chk(q, 8'h81);
        set(1'b0, 1'b0, 1'b0);
        pins(3'b100);
        while (cyc < T_DAT + 10) @(posedge core_clk);
        rd(7'h51, q, ok);
        chk(q, 8'h00);
        wrap_up();
    end

    // tests need about 1.3 ms; this stays under 100k core cycles
    initial begin
        #1800000;
        num_errors++;
        wrap_up();
    end
endmodule : test_omcs_top
